// >>> rtl/boie_map.svh
// Overview of operation
// - Complement-register pattern 0010 01df ffff writes the inverted file register to the destination and updates zero.
// - Destination bit 0 sends the result to the accumulator, bit 1 writes it back to the addressed file register.
// - Decrement-register pattern 0000 11df ffff writes the register minus one to the destination and updates zero.
// - Decrement-skip-zero pattern 0010 11df ffff writes the register minus one, leaves flags, and on a zero result discards the fetched next instruction as a no-op.
// - Decrement-skip-zero takes one cycle, or two when it skips; every other instruction here is one word and one cycle.
// - Or-literal pattern 1101 kkkk kkkk ors the accumulator with the literal into the accumulator and updates zero.
// - Or-accumulator-register pattern 0001 00df ffff ors accumulator and register to the destination and updates zero.
// - Move-register pattern 0010 00df ffff copies the register to the destination and updates zero, so destination 1 tests it.
// - Load-literal pattern 1100 kkkk kkkk loads the literal into the accumulator and leaves every flag alone.
`ifndef BOIE_MAP_SVH
`define BOIE_MAP_SVH
// ----------------------------------------
// Opcode patterns, upper bits
// ----------------------------------------
`define BOIE_OP6_COMPLEMENT 6'h09
`define BOIE_OP6_DECREMENT  6'h03
`define BOIE_OP6_DEC_SKIP   6'h0b
`define BOIE_OP6_OR_ACC_REG 6'h04
`define BOIE_OP6_MOVE_REG   6'h08
`define BOIE_OP4_OR_LITERAL 4'hd
`define BOIE_OP4_LOAD_LIT   4'hc
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define BOIE_DEST_BIT       5
`define BOIE_ACC_RESET      8'h00
`define BOIE_ZERO_RESET     1'h0
`endif

// >>> rtl/boie_pkg.sv
package boie_pkg;
  typedef enum logic [6:0] {
    BOIE_NONE     = 7'h01,
    BOIE_COMPL    = 7'h02,
    BOIE_DEC      = 7'h04,
    BOIE_DEC_SKIP = 7'h08,
    BOIE_OR_LIT   = 7'h10,
    BOIE_OR_REG   = 7'h20,
    BOIE_MOVE     = 7'h40
  } boie_op_t;
  typedef enum logic [1:0] {
    BOIE_RUN  = 2'h1,
    BOIE_SKIP = 2'h2
  } boie_state_t;
endpackage

// >>> rtl/boie_dec_if.sv
`timescale 1ns/10ps
interface boie_dec_if;
  logic [11:0]       instr;
  boie_pkg::boie_op_t op;
  logic              dest_reg;
  modport dec (input instr, output op, output dest_reg);
  modport exe (output instr, input op, input dest_reg);
endinterface

// >>> rtl/boie_decoder.sv
`timescale 1ns/10ps
`include "boie_map.svh"
module boie_decoder (
  // Decode link
  boie_dec_if.dec dl
);
  always_comb begin
    dl.dest_reg = dl.instr[`BOIE_DEST_BIT];
    case (dl.instr[11:6])
      `BOIE_OP6_COMPLEMENT: dl.op = boie_pkg::BOIE_COMPL;
      `BOIE_OP6_DECREMENT:  dl.op = boie_pkg::BOIE_DEC;
      `BOIE_OP6_DEC_SKIP:   dl.op = boie_pkg::BOIE_DEC_SKIP;
      `BOIE_OP6_OR_ACC_REG: dl.op = boie_pkg::BOIE_OR_REG;
      `BOIE_OP6_MOVE_REG:   dl.op = boie_pkg::BOIE_MOVE;
      default: begin
        case (dl.instr[11:8])
          `BOIE_OP4_OR_LITERAL: dl.op = boie_pkg::BOIE_OR_LIT;
          `BOIE_OP4_LOAD_LIT:   dl.op = boie_pkg::BOIE_MOVE;
          default:              dl.op = boie_pkg::BOIE_NONE;
        endcase
        if (dl.instr[11:8] == `BOIE_OP4_LOAD_LIT) begin
          dl.op = boie_pkg::BOIE_NONE;
        end
      end
    endcase
  end
endmodule // boie_decoder

// >>> rtl/boie_exec.sv
`timescale 1ns/10ps
`include "boie_map.svh"
module boie_exec (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Instruction from fetch
  input  wire logic        instr_valid,
  input  wire logic [11:0] instr,
  // File register read port
  output logic      [4:0]  file_addr,
  input  wire logic [7:0]  file_rdata,
  // File register write port
  output logic             file_we,
  output logic      [4:0]  file_waddr,
  output logic      [7:0]  file_wdata,
  // Architectural state
  output logic      [7:0]  acc,
  output logic             zero_flag,
  output logic             skip_cycle,
  output logic             retired
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]             acc;
    logic                   zero;
    boie_pkg::boie_state_t  state;
    logic                   we;
    logic [4:0]             waddr;
    logic [7:0]             wdata;
    logic                   retired;
  } boie_regs_t;

  boie_regs_t r;
  boie_regs_t next_r;
  boie_dec_if dl ();

  boie_decoder u_dec (
    .dl (dl)
  );

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  assign dl.instr  = instr;
  // Read port is combinational so the operand arrives in the same cycle
  assign file_addr = instr[4:0];

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  always_comb begin
    logic [7:0] res;
    logic       wr_dest;
    logic       upd_z;
    logic       lit_acc;
    res     = 8'h00;
    wr_dest = 1'b0;
    upd_z   = 1'b0;
    lit_acc = 1'b0;
    next_r         = r;
    next_r.we      = 1'b0;
    next_r.retired = 1'b0;
    if (r.state == boie_pkg::BOIE_SKIP) begin
      // Prefetched word is dropped: a no-op second cycle
      next_r.state = boie_pkg::BOIE_RUN;
    end else if (instr_valid) begin
      next_r.retired = 1'b1;
      case (dl.op)
        boie_pkg::BOIE_COMPL: begin
          res = ~file_rdata;
          wr_dest = 1'b1;
          upd_z = 1'b1;
        end
        boie_pkg::BOIE_DEC: begin
          res = file_rdata - 8'h01;
          wr_dest = 1'b1;
          upd_z = 1'b1;
        end
        boie_pkg::BOIE_DEC_SKIP: begin
          res = file_rdata - 8'h01;
          wr_dest = 1'b1;
          if (is_zero(res)) begin
            next_r.state = boie_pkg::BOIE_SKIP;
          end
        end
        boie_pkg::BOIE_OR_REG: begin
          res = r.acc | file_rdata;
          wr_dest = 1'b1;
          upd_z = 1'b1;
        end
        boie_pkg::BOIE_MOVE: begin
          res = file_rdata;
          wr_dest = 1'b1;
          upd_z = 1'b1;
        end
        boie_pkg::BOIE_OR_LIT: begin
          res = r.acc | instr[7:0];
          lit_acc = 1'b1;
          upd_z = 1'b1;
        end
        default: begin
          if (instr[11:8] == `BOIE_OP4_LOAD_LIT) begin
            res = instr[7:0];
            lit_acc = 1'b1;
          end else begin
            next_r.retired = 1'b0;
          end
        end
      endcase
      if (wr_dest && dl.dest_reg) begin
        next_r.we    = 1'b1;
        next_r.waddr = instr[4:0];
        next_r.wdata = res;
      end else if (wr_dest || lit_acc) begin
        next_r.acc = res;
      end
      if (upd_z) begin
        next_r.zero = is_zero(res);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '{acc: `BOIE_ACC_RESET, zero: `BOIE_ZERO_RESET, state: boie_pkg::BOIE_RUN,
             we: 1'b0, waddr: 5'h00, wdata: 8'h00, retired: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign acc        = r.acc;
  assign zero_flag  = r.zero;
  assign skip_cycle = (r.state == boie_pkg::BOIE_SKIP);
  assign file_we    = r.we;
  assign file_waddr = r.waddr;
  assign file_wdata = r.wdata;
  assign retired    = r.retired;
endmodule // boie_exec

// >>> tb/boie_exec_checker.sv
`timescale 1ns/10ps
module boie_exec_checker (
  input wire logic        clk, reset, instr_valid, file_we, zero_flag, skip_cycle, retired,
  input wire logic [11:0] instr,
  input wire logic [7:0]  file_rdata, file_wdata, acc
);
  wire       t = instr_valid && !skip_cycle;
  wire [5:0] o = instr[11:6];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_lit_load: assert property (t && instr[11:8] == 4'hc |=>
    acc == $past(instr[7:0]) && $stable(zero_flag)) else $error("load");
  chk_or_lit: assert property (t && instr[11:8] == 4'hd |=>
    acc == ($past(acc) | $past(instr[7:0])) && zero_flag == (acc == 8'h00)) else $error("orl");
  chk_compl_dest: assert property (t && o == 6'h09 && instr[5] |=>
    file_we && file_wdata == ~$past(file_rdata)) else $error("comp");
  chk_dec_acc: assert property (t && o == 6'h03 && !instr[5] |=>
    !file_we && acc == $past(file_rdata) - 8'h01) else $error("dec");
  chk_or_reg: assert property (t && o == 6'h04 && !instr[5] |=>
    acc == ($past(acc) | $past(file_rdata))) else $error("orr");
  chk_move_zero: assert property (t && o == 6'h08 |=>
    zero_flag == ($past(file_rdata) == 8'h00)) else $error("move");
  chk_skip_flag: assert property (t && o == 6'h0b |=>
    $stable(zero_flag) && skip_cycle == ($past(file_rdata) == 8'h01)) else $error("skip");
  chk_skip_void: assert property (skip_cycle |=>
    !skip_cycle && !retired && !file_we && $stable(acc)) else $error("void");
  chk_unknown_idle: assert property (t && !(o inside {6'h09, 6'h03, 6'h0b, 6'h04, 6'h08})
    && instr[11:9] != 3'b110 |=> !retired && !file_we && $stable(acc) && $stable(zero_flag))
    else $error("unknown");
endmodule // boie_exec_checker
bind boie_exec boie_exec_checker chk_u (.clk, .reset, .instr_valid, .file_we, .zero_flag,
  .skip_cycle, .retired, .instr, .file_rdata, .file_wdata, .acc);

// >>> tb/boie_file_model.sv
`timescale 1ns/10ps
module boie_file_model (
  input wire logic       clk, file_we,
  input wire logic [4:0] file_addr, file_waddr,
  input wire logic [7:0] file_wdata,
  output logic     [7:0] file_rdata
);
  logic [7:0] mem [32] = '{default: 8'h00};
  // Forwarded so a back-to-back read sees the new byte
  assign file_rdata = file_we && file_waddr == file_addr ? file_wdata : mem[file_addr];
  always @(posedge clk) if (file_we) mem[file_waddr] <= file_wdata;
endmodule // boie_file_model

// >>> tb/byte_op_instruction_exec_tb.sv
`timescale 1ns/10ps
module byte_op_instruction_exec_tb;
  logic clk = 0, reset = 1, instr_valid = 0, file_we, zero_flag, skip_cycle, retired, ez = 0;
  logic [11:0] instr = 0;
  logic [4:0]  file_addr, file_waddr;
  logic [7:0]  file_rdata, file_wdata, acc, ea = 0, em [32] = '{default: 8'h00};
  logic [5:0]  op [5] = '{6'h09, 6'h03, 6'h0b, 6'h04, 6'h08};
  logic [11:0] cc [11] = '{12'hc00, 12'hd00, 12'hcff, 12'h122, 12'h262, 12'hc01, 12'h122,
    12'h2e2, 12'h222, 12'h0e2, 12'h2c2};
  int fails = 0, n_checks = 0;
  always #10 clk = ~clk;
  boie_exec dut_u (.clk, .reset, .instr_valid, .instr, .file_addr, .file_rdata, .file_we,
    .file_waddr, .file_wdata, .acc, .zero_flag, .skip_cycle, .retired);
  boie_file_model m_u (.clk, .file_we, .file_addr, .file_waddr, .file_wdata, .file_rdata);
  task automatic ck(input logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic results;
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic ex(input logic [11:0] i);
    logic [7:0] f, r;
    logic zu, wf, sk;
    f = em[i[4:0]];
    zu = 1;
    case (i[11:6])
      6'h09: r = ~f;
      6'h03, 6'h0b: r = f - 8'h01;
      6'h04: r = ea | f;
      6'h08: r = f;
      default: {zu, r} = {i[8], i[8] ? ea | i[7:0] : i[7:0]};
    endcase
    sk = i[11:6] == 6'h0b && r == 0;
    if (i[11:6] == 6'h0b) zu = 0;
    wf = !i[11] && i[5];
    if (wf) em[i[4:0]] = r;
    else ea = r;
    if (zu) ez = r == 0;
    instr = i;
    instr_valid = 1;
    #1 ck(file_addr, 8'(i[4:0]));
    @(posedge clk) #2;
    ck(acc, ea);
    ck({zero_flag, file_we, retired, skip_cycle}, {ez, wf, 1'b1, sk});
    if (wf) ck(file_wdata, r);
    if (wf) ck(file_waddr, 8'(i[4:0]));
    if (sk) begin
      // Junk word in the discard slot must not land
      instr = 12'($urandom);
      @(posedge clk) #2;
      ck({file_we, retired, skip_cycle}, 0);
      ck(acc, ea);
    end
  endtask
  initial begin
    int k;
    logic [11:0] i;
    void'($urandom(34));
    repeat (4) @(posedge clk);
    #2 reset = 0;
    for (int j = 0; j < 32; j++) begin
      ex({4'hc, 8'($urandom)});
      ex(12'h120 + j[11:0]);
    end
    foreach (cc[j]) ex(cc[j]);
    // Idle word and unknown opcode must leave state alone
    instr_valid = 0;
    instr = 12'h262;
    @(posedge clk) #2;
    ck({file_we, retired, skip_cycle}, 0);
    ck(acc, ea);
    instr_valid = 1;
    instr = 12'h000;
    @(posedge clk) #2;
    ck({zero_flag, file_we, retired, skip_cycle}, {ez, 3'b000});
    ck(acc, ea);
    // Mid-run reset clears the architectural state
    reset = 1;
    #2 ck(acc, 8'h00);
    ck({zero_flag, file_we, retired, skip_cycle}, 0);
    @(posedge clk) #2;
    reset = 0;
    ea = 8'h00;
    ez = 1'b0;
    repeat (400) begin
      i = 12'($urandom);
      k = $urandom % 7;
      if (k < 5) i[11:6] = op[k];
      else i[11:8] = k == 5 ? 4'hc : 4'hd;
      ex(i);
    end
    results;
  end
endmodule // byte_op_instruction_exec_tb
